// >>> design/sar_adc_conversion_control.sv
// Conversion sequencing, start logic and registers of a 10-bit SAR converter.
// Assumes the DAC and comparator outside, comparator output in this clock domain.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Start sources
  input  wire logic        external_start_pin,
  input  wire pwm_t        pwm,
  // CPU power state
  input  wire pwr_t        power_control_reg,
  // Analog front end
  input  wire logic        comp_hi,
  output analog_t          analog,
  // Completion
  output logic             conv_irq,
  output logic             wake_cpu
);

  // ******************************
  // Decoders
  // ******************************

  // Trial code: result so far plus the bit under test
  function automatic logic [9:0] trial_code(input phase_t ph,
                                            input logic [5:0] cnt,
                                            input logic [9:0] sar);
    logic [5:0] idx;
    idx = LAST_CNT - cnt;
    if (ph == PH_CONV && cnt >= SAMPLE_CNT) begin
      trial_code = sar | (10'h001 << idx[3:0]);
    end else begin
      trial_code = sar;
    end
  endfunction

  // Register read mux
  function automatic logic [7:0] reg_read(input logic [7:0] a, input state_t s);
    unique case (a)
      OFS_CTRL: reg_read = {s.res[1:0], s.hw_en, s.done, s.start, s.chan};
      OFS_RESH: reg_read = s.res[9:2];
      OFS_TRIG: reg_read = {4'h0, s.trig};
      OFS_DLY:  reg_read = s.dly;
      OFS_AUX:  reg_read = {5'h00, s.aux};
      default:  reg_read = 8'h00;
    endcase
  endfunction

  state_t st_q;
  state_t st_d;

  logic       req;
  logic       wr_take;
  logic       pin_rise;
  logic [2:0] pwm_rise;
  logic [2:0] pwm_fall;
  logic [1:0] trig_ch;
  logic       trig_ev;

  // Bus handshake: one wait cycle, answer on the second
  assign req         = read | write;
  assign wr_take     = write & st_q.ack & byteenable[0];
  assign waitrequest = req & ~st_q.ack;
  assign readdata    = st_q.rdata;

  // Pin edge from second and third stages only
  assign pin_rise = st_q.pin_s2 & ~st_q.pin_s3;

  // Even channel edges and selection
  assign pwm_rise = pwm.even & ~st_q.pwm_prev;
  assign pwm_fall = ~pwm.even & st_q.pwm_prev;
  assign trig_ch  = st_q.trig[1:0];

  // Trigger event decode
  always_comb begin
    trig_ev = 1'b0;
    if (trig_ch != 2'b11) begin
      unique case (trig_type_t'(st_q.trig[3:2]))
        TRIG_RISE:   trig_ev = pwm_rise[trig_ch];
        TRIG_FALL:   trig_ev = pwm_fall[trig_ch];
        TRIG_CENTRE: trig_ev = pwm.centre & pwm.centre_mode;
        TRIG_OFF:    trig_ev = 1'b0;
      endcase
    end
  end

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    logic start_req;
    start_req = 1'b0;
    st_d = st_q;
    st_d.pin_s1   = external_start_pin;
    st_d.pin_s2   = st_q.pin_s1;
    st_d.pin_s3   = st_q.pin_s2;
    st_d.pwm_prev = pwm.even;
    st_d.ack      = req & ~st_q.ack;
    st_d.wake     = 1'b0;

    // Register writes
    if (wr_take) begin
      unique case (address)
        OFS_CTRL: begin
          st_d.chan  = writedata[2:0];
          st_d.hw_en = writedata[CTRL_HWEN];
          if (writedata[CTRL_START] && st_q.phase == PH_IDLE) begin
            start_req = 1'b1;
          end
          if (!writedata[CTRL_DONE]) begin
            st_d.done = 1'b0;
          end
        end
        OFS_TRIG: st_d.trig = writedata[3:0];
        OFS_DLY:  st_d.dly  = writedata[7:0];
        OFS_AUX:  st_d.aux  = writedata[2:0];
        default:  ;
      endcase
    end

    // Pin start, also while the CPU idles
    if (pin_rise && st_q.hw_en) begin
      start_req = 1'b1;
    end

    // PWM trigger with programmed delay
    if (st_q.dpend) begin
      if (st_q.dcnt == 8'h00) begin
        st_d.dpend = 1'b0;
        start_req  = 1'b1;
      end else begin
        st_d.dcnt = st_q.dcnt - 8'h01;
      end
    end else if (trig_ev && st_q.hw_en) begin
      st_d.dpend = 1'b1;
      st_d.dcnt  = st_q.dly;
    end

    // Conversion sequence
    unique case (st_q.phase)
      PH_IDLE: begin
        if (start_req) begin
          st_d.phase = PH_CONV;
          st_d.cnt   = 6'h00;
          st_d.sar   = 10'h000;
          st_d.start = 1'b1;
        end
      end
      PH_CONV: begin
        // New starts fall through unused here
        if (st_q.cnt >= SAMPLE_CNT && comp_hi) begin
          st_d.sar = st_q.dac;
        end
        if (st_q.cnt == LAST_CNT) begin
          st_d.phase = PH_IDLE;
          st_d.done  = 1'b1;
          st_d.start = 1'b0;
          if (!st_q.done) begin
            st_d.res = st_d.sar;
          end
          st_d.wake = power_control_reg.idle_request
                    | power_control_reg.powerdown_request;
        end else begin
          st_d.cnt = st_q.cnt + 6'h01;
        end
      end
    endcase

    st_d.dac = trial_code(st_d.phase, st_d.cnt, st_d.sar);

    // Read data latched in the wait cycle
    if (req && !st_q.ack) begin
      st_d.rdata = {24'h000000, reg_read(address, st_q)};
    end
  end

  // ******************************
  // State register
  // ******************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.phase <= PH_IDLE;
      st_q.chan  <= CTRL_RST[2:0];
      st_q.hw_en <= CTRL_RST[CTRL_HWEN];
      st_q.trig  <= TRIG_RST;
      st_q.dly   <= DLY_RST;
      st_q.aux   <= AUX_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ******************************
  // Outputs
  // ******************************

  // Analog control from state flops
  assign analog.chan_sel   = st_q.chan;
  assign analog.ch0_opamp  = st_q.aux[AUX_OPAMP];
  assign analog.ch1_vbr    = st_q.aux[AUX_CH1];
  assign analog.rc_clk_sel = st_q.aux[AUX_RC];
  assign analog.sample     = (st_q.phase == PH_CONV) && (st_q.cnt < SAMPLE_CNT);
  assign analog.dac_code   = st_q.dac;

  // Interrupt level and wake pulse
  assign conv_irq = st_q.done;
  assign wake_cpu = st_q.wake;

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_swonly_no_pin: assert property (
    st_q.phase == PH_IDLE && !st_q.hw_en && !wr_take && !st_q.dpend
    |=> st_q.phase == PH_IDLE)
    else $error("start without software while hardware start off");

  a_pin_starts: assert property (
    pin_rise && st_q.hw_en && st_q.phase == PH_IDLE
    |=> st_q.phase == PH_CONV && st_q.cnt == 6'h00 && st_q.start)
    else $error("pin edge did not start conversion");

  a_done_sets: assert property (
    st_q.phase == PH_CONV && st_q.cnt == LAST_CNT |=> st_q.done && conv_irq)
    else $error("done flag not set at end");

  a_result_store: assert property (
    st_q.phase == PH_CONV && st_q.cnt == LAST_CNT && !st_q.done
    |=> st_q.res == $past(st_d.sar))
    else $error("result not stored");

  a_conv_length: assert property (
    $rose(st_q.phase == PH_CONV)
    |-> ##33 (st_q.cnt == LAST_CNT) ##1 st_q.phase == PH_IDLE)
    else $error("conversion length wrong");

  a_start_clear: assert property (
    $rose(st_q.done) |-> !st_q.start)
    else $error("start bit still set with done");

  a_busy_ignore: assert property (
    st_q.phase == PH_CONV && st_q.cnt != LAST_CNT
    |=> st_q.phase == PH_CONV && st_q.cnt == $past(st_q.cnt) + 6'h01)
    else $error("conversion disturbed");

  a_result_hold: assert property (
    st_q.done |=> $stable(st_q.res))
    else $error("result overwritten while done");

  a_delay_load: assert property (
    trig_ev && st_q.hw_en && !st_q.dpend
    |=> st_q.dpend && st_q.dcnt == $past(st_q.dly))
    else $error("trigger delay not loaded");

  a_wake_pulse: assert property (
    $rose(st_q.done) && $past(power_control_reg.idle_request)
    |-> wake_cpu ##1 !wake_cpu)
    else $error("idle CPU not woken");

  a_sw_starts: assert property (
    wr_take && address == OFS_CTRL && writedata[CTRL_START] && st_q.phase == PH_IDLE
    |=> st_q.phase == PH_CONV && st_q.start)
    else $error("software start not taken");

  a_pin_idle: assert property (
    pin_rise && st_q.hw_en && st_q.phase == PH_IDLE && power_control_reg.idle_request
    |=> st_q.phase == PH_CONV)
    else $error("pin start lost while CPU idles");

  a_start_held: assert property (
    st_q.phase == PH_CONV |-> st_q.start)
    else $error("start bit low during conversion");

  a_chan_drive: assert property (
    wr_take && address == OFS_CTRL
    |=> analog.chan_sel == $past(writedata[2:0]))
    else $error("channel select not driven");

  a_opamp_route: assert property (
    wr_take && address == OFS_AUX
    |=> analog.ch0_opamp == $past(writedata[AUX_OPAMP]))
    else $error("opamp routing not driven");

  a_vbr_route: assert property (
    wr_take && address == OFS_AUX
    |=> analog.ch1_vbr == $past(writedata[AUX_CH1]))
    else $error("reference routing not driven");

  a_no_trig_ch: assert property (
    !st_q.dpend && trig_ch == 2'b11 |=> !st_q.dpend)
    else $error("trigger taken with no channel");

  a_rise_event: assert property (
    st_q.hw_en && !st_q.dpend && st_q.trig[3:2] == TRIG_RISE && trig_ch != 2'b11
    && pwm_rise[trig_ch] |=> st_q.dpend)
    else $error("rising edge trigger missed");

  a_fall_event: assert property (
    st_q.hw_en && !st_q.dpend && st_q.trig[3:2] == TRIG_FALL && trig_ch != 2'b11
    && pwm_fall[trig_ch] |=> st_q.dpend)
    else $error("falling edge trigger missed");

  a_centre_event: assert property (
    st_q.hw_en && !st_q.dpend && st_q.trig[3:2] == TRIG_CENTRE && trig_ch != 2'b11
    && pwm.centre && pwm.centre_mode |=> st_q.dpend)
    else $error("centre trigger missed");

  a_delay_start: assert property (
    st_q.dpend && st_q.dcnt == 8'h00 && st_q.phase == PH_IDLE
    |=> st_q.phase == PH_CONV)
    else $error("delayed start not taken");

  a_wake_pd: assert property (
    $rose(st_q.done) && $past(power_control_reg.powerdown_request)
    |-> wake_cpu)
    else $error("powered down CPU not woken");

  a_trial_keep: assert property (
    st_q.phase == PH_CONV && st_q.cnt >= SAMPLE_CNT
    |=> st_q.sar == ($past(comp_hi) ? $past(st_q.dac) : $past(st_q.sar)))
    else $error("trial bit decision wrong");

  a_pin_single: assert property (
    pin_rise |=> !pin_rise)
    else $error("pin start not single cycle");

  c_sw_start:  cover property (wr_take && writedata[CTRL_START] && !st_q.start);
  c_pwm_start: cover property (st_q.dpend ##1 !st_q.dpend ##1 st_q.phase == PH_CONV);
  c_hold:      cover property (st_q.done && st_q.phase == PH_CONV && st_q.cnt == LAST_CNT);
  c_pin_idle:  cover property (pin_rise && st_q.hw_en && power_control_reg.idle_request);
  c_pd_wake:   cover property (wake_cpu && power_control_reg.powerdown_request);

endmodule // sar_adc_conversion_control

`default_nettype wire

// >>> common/adc_pkg.sv
// Constants, types and state layout of the conversion control block.
// Assumes one 125 MHz clock that also serves as the converter clock.
package adc_pkg;

  // ******************************
  // Register byte offsets
  // ******************************
  localparam logic [7:0] OFS_CTRL = 8'h00; // converter_control_status
  localparam logic [7:0] OFS_RESH = 8'h04; // conversion_result_high
  localparam logic [7:0] OFS_TRIG = 8'h08; // pwm_trigger_config
  localparam logic [7:0] OFS_DLY  = 8'h0C; // trigger_delay_value
  localparam logic [7:0] OFS_AUX  = 8'h10; // aux_control_two

  // ******************************
  // Field positions
  // ******************************
  localparam int CTRL_START = 3;
  localparam int CTRL_DONE  = 4;
  localparam int CTRL_HWEN  = 5;
  localparam int AUX_OPAMP  = 0;
  localparam int AUX_CH1    = 1;
  localparam int AUX_RC     = 2;

  // ******************************
  // Reset values and timing
  // ******************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] TRIG_RST = 4'hC;  // Trigger off
  localparam logic [7:0] DLY_RST  = 8'h00;
  localparam logic [2:0] AUX_RST  = 3'h0;
  localparam logic [5:0] CONV_CYCLES = 6'h22; // 34 converter clocks
  localparam logic [5:0] LAST_CNT    = CONV_CYCLES - 6'h01;
  localparam logic [5:0] SAMPLE_CNT  = LAST_CNT - 6'h09; // 10 trials

  // ******************************
  // Types
  // ******************************
  typedef enum logic [1:0] {
    TRIG_RISE   = 2'b00,
    TRIG_FALL   = 2'b01,
    TRIG_CENTRE = 2'b10,
    TRIG_OFF    = 2'b11
  } trig_type_t;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_CONV = 1'b1
  } phase_t;

  typedef struct packed {
    logic [2:0] chan_sel;
    logic       ch0_opamp;
    logic       ch1_vbr;
    logic       rc_clk_sel;
    logic       sample;
    logic [9:0] dac_code;
  } analog_t;

  typedef struct packed {
    logic [2:0] even;       // Channels 0, 2, 4
    logic       centre;     // Centre point pulse
    logic       centre_mode;
  } pwm_t;

  typedef struct packed {
    logic idle_request;
    logic powerdown_request;
  } pwr_t;

  typedef struct packed {
    phase_t      phase;
    logic [5:0]  cnt;
    logic [9:0]  sar;
    logic [9:0]  dac;
    logic [9:0]  res;
    logic        done;
    logic        start;
    logic        hw_en;
    logic [2:0]  chan;
    logic [3:0]  trig;
    logic [7:0]  dly;
    logic [7:0]  dcnt;
    logic        dpend;
    logic [2:0]  aux;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
    logic [2:0]  pwm_prev;
    logic        ack;
    logic [31:0] rdata;
    logic        wake;
  } state_t;

endpackage

// >>> verif/sar_front_model.sv
// Behavioural DAC, input multiplexer and comparator beside the control block.
// Assumes channel controls and dac_code from the block, same clock domain.
`timescale 1ns/1ps
`default_nettype none

module sar_front_model
  import adc_pkg::*;
(
  // Clock
  input  wire logic            ref_clk,
  // Controls from the block
  input  wire analog_t         analog,
  // Input levels as codes
  input  wire logic [7:0][9:0] vin,
  input  wire logic [9:0]      opamp_code,
  input  wire logic [9:0]      vbr_code,
  // Comparator
  output logic                 comp_hi
);
  logic [9:0] level;
  logic       noise_q = 1'b0;

  // Channel mux with alternative sources
  always_comb begin
    level = vin[analog.chan_sel];
    if (analog.chan_sel == 3'h0 && analog.ch0_opamp) level = opamp_code;
    if (analog.chan_sel == 3'h1 && analog.ch1_vbr) level = vbr_code;
  end

  // Meaningless output while sampling
  always_ff @(posedge ref_clk) begin
    noise_q <= ~noise_q;
  end

  // High while input at or above DAC level
  assign comp_hi = analog.sample ? noise_q : (level >= analog.dac_code);
endmodule // sar_front_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench of the conversion control block.
// Assumes the front-end model and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import adc_pkg::*;
;
  logic            ref_clk, rst_n, read, write, waitrequest, external_start_pin;
  logic            comp_hi, conv_irq, wake_cpu, samp_p, irq_p, w;
  logic [7:0]      address, q;
  logic [31:0]     writedata, readdata, lf;
  logic [3:0]      byteenable;
  pwm_t            pwm;
  pwr_t            power_control_reg;
  analog_t         analog;
  logic [7:0][9:0] vin;
  logic [9:0]      opc, vbc, e;
  logic            note[$];
  int              n_mismatch, checked, cyc, lat, base;
  logic [7:0]      ofs[6] = '{OFS_CTRL, OFS_RESH, OFS_TRIG, OFS_DLY, OFS_AUX, 8'h14};
  logic [7:0]      rv[6] = '{CTRL_RST, 8'h00, {4'h0, TRIG_RST}, DLY_RST, {5'h00, AUX_RST}, 8'h00};

  sar_adc_conversion_control DUT (.ref_clk, .rst_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .external_start_pin, .pwm, .power_control_reg,
    .comp_hi, .analog, .conv_irq, .wake_cpu);
  sar_front_model FE (.ref_clk, .analog, .vin, .opamp_code(opc), .vbr_code(vbc), .comp_hi);

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checked++;
    if (sn !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
      n_mismatch++;
    end
  endtask

  // One Avalon access, held until waitrequest low
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    address   <= a;
    writedata <= {24'h000000, d};
    read      <= !wr;
    write     <= wr;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task wait_done;
    while (conv_irq !== 1'b1) @(posedge ref_clk);
  endtask

  task pin_pulse;
    external_start_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    external_start_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ******************************
  // Clock, monitor, watchdog
  // ******************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Latency from conversion entry and wake pulse at done rise
  always @(posedge ref_clk) begin
    if (analog.sample === 1'b1 && samp_p !== 1'b1) cyc = 0;
    else cyc = cyc + 1;
    if (conv_irq === 1'b1 && irq_p !== 1'b1) begin
      if (note.size() == 0) chk("unexpected done", 0, 1);
      else begin
        w = note.pop_front();
        chk("latency", 34, cyc);
        chk("wake", w, wake_cpu);
      end
    end
    samp_p = analog.sample;
    irq_p  = conv_irq;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up;
  end

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    {rst_n, read, write, external_start_pin, samp_p, irq_p} = '0;
    address = '0; writedata = '0; byteenable = 4'hF; pwm = '0;
    power_control_reg = '0; vin = '0; opc = 10'h155; vbc = 10'h2AA; lf = 32'h89E607F1;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b1, 8'h14, 8'hFF);
    byteenable <= 4'hE;
    bus(1'b1, OFS_DLY, 8'h5A);
    byteenable <= 4'hF;
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 8'h00);
      chk("reset value", rv[i], q);
    end
    $display("test registers done");
    for (int ch = 0; ch < 8; ch++) begin
      lf = lfsr_next(lf);
      vin[ch] <= lf[9:0];
      bus(1'b1, OFS_AUX, {5'h00, lf[12:10]});
      e = (ch == 0 && lf[10]) ? opc : (ch == 1 && lf[11]) ? vbc : lf[9:0];
      note.push_back(1'b0);
      bus(1'b1, OFS_CTRL, 8'h08 | ch[7:0]);
      bus(1'b1, OFS_CTRL, 8'h08 | ch[7:0]);
      wait_done;
      bus(1'b0, OFS_RESH, 8'h00);
      chk("result high", e[9:2], q);
      bus(1'b0, OFS_CTRL, 8'h00);
      chk("control", {e[1:0], 3'b010, ch[2:0]}, q);
      bus(1'b1, OFS_CTRL, 8'h00);
    end
    note.push_back(1'b0);
    bus(1'b1, OFS_CTRL, 8'h0A);
    wait_done;
    e = vin[2];
    vin[2] <= ~vin[2];
    bus(1'b1, OFS_CTRL, 8'h1A);
    do bus(1'b0, OFS_CTRL, 8'h00); while (q[3] !== 1'b0);
    bus(1'b0, OFS_RESH, 8'h00);
    chk("held result", e[9:2], q);
    bus(1'b1, OFS_CTRL, 8'h00);
    $display("test software start done");
    pin_pulse;
    repeat (50) @(posedge ref_clk);
    chk("pin ignored", 0, conv_irq);
    bus(1'b1, OFS_CTRL, 8'h20);
    power_control_reg.idle_request <= 1'b1;
    note.push_back(1'b1);
    pin_pulse;
    pin_pulse;
    bus(1'b1, OFS_CTRL, 8'h28);
    wait_done;
    repeat (40) @(posedge ref_clk);
    bus(1'b0, OFS_CTRL, 8'h00);
    chk("start bit", 0, q[3]);
    power_control_reg.idle_request <= 1'b0;
    bus(1'b1, OFS_CTRL, 8'h20);
    $display("test pin start done");
    bus(1'b1, OFS_AUX, 8'h01 << AUX_RC);
    @(posedge ref_clk);
    chk("rc select", 1, analog.rc_clk_sel);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 3; c++) begin
        pwm.even <= (t == 1) ? 3'b111 : 3'b000;
        pwm.centre_mode <= (t == 2);
        power_control_reg.powerdown_request <= (c == 1);
        lf = lfsr_next(lf);
        bus(1'b1, OFS_DLY, {4'h0, lf[3:0]});
        bus(1'b1, OFS_TRIG, {4'h0, t[1:0], c[1:0]});
        note.push_back(c == 1);
        if (t == 2) pwm.centre <= 1'b1;
        else pwm.even[c] <= ~pwm.even[c];
        @(posedge ref_clk);
        pwm.centre <= 1'b0;
        lat = 1;
        while (analog.sample !== 1'b1) begin
          @(posedge ref_clk);
          lat++;
        end
        if (c == 0) base = lat - lf[3:0];
        else chk("trigger delay", base + lf[3:0], lat);
        wait_done;
        bus(1'b1, OFS_TRIG, 8'h0C);
        bus(1'b1, OFS_CTRL, 8'h20);
      end
    end
    pwm.even <= 3'b000;
    bus(1'b1, OFS_TRIG, 8'h03);
    pwm.even <= 3'b111;
    repeat (60) @(posedge ref_clk);
    chk("no trigger", 0, conv_irq);
    $display("test pwm trigger done");
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
